// >>> hw/dcc_channel.sv
`timescale 1ns/1ns
// Notes on behaviour
// (R1) after each source beat the source address steps up, down, or holds
// (R2) software picks hold stepping when the source is a fixed-address fifo
// (R3) after each destination beat the destination address steps likewise
// (R4) software picks hold stepping when the destination is a fixed fifo
// (R5) hsize of each source read is the programmed source width
// (R6) software keeps the source width at 32 bits or less
// (R7) width codes mean 8,16,32,64,128 bits, and 256 from 101 upward
// (R8) channel irq enable gates the interrupt output; resets to enabled
// (R9) raw status flags still set while the channel irq enable is off
// (R10) a go request moves 1,4,8,...,256 items per burst code, reset 001
module dcc_channel #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hready,
  input wire logic hresp,
  output logic irq
);
  localparam int STAT_W = dcc_pkg::STAT_W;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r, irq_r;
  logic aw_held_r, w_held_r, hwrite_r;
  logic [1:0] bresp_r, rresp_r, htrans_r;
  logic [31:0] rdata_r, wdata_r, src_addr_r, dst_addr_r, haddr_r, hwdata_r;
  logic [7:0] awaddr_r;
  logic [3:0] wstrb_r;
  logic [16:0] ctl_r;
  logic [STAT_W-1:0] status_r, mask_r;
  logic [8:0] cnt_r;
  logic [2:0] hsize_r;
  dcc_pkg::dcc_state_t state_r, state_nxt;
  // byte lanes of the held write data
  logic [31:0] wmask;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_lane
      assign wmask[gi*8 +: 8] = {8{wstrb_r[gi]}};
    end
  endgenerate
  function automatic logic [5:0] width_bytes(input logic [2:0] code);
    width_bytes = (code >= dcc_pkg::WIDTH_CAP) ? dcc_pkg::BYTES_CAP
                : 6'(6'h01 << code);
  endfunction
  function automatic logic [8:0] burst_items(input logic [2:0] code);
    burst_items = (code == 3'h0) ? 9'h001 : 9'(9'h002 << code);
  endfunction
  function automatic logic [31:0] step_addr(input logic [31:0] a,
    input logic [1:0] step, input logic [5:0] bytes);
    step_addr = (step == dcc_pkg::STEP_INC) ? a + {26'h0, bytes}
      : (step == dcc_pkg::STEP_DEC) ? a - {26'h0, bytes} : a;
  endfunction
  // control word fields
  wire irq_en = ctl_r[dcc_pkg::CTL_IRQ_EN];
  wire [2:0] dst_xfer_width = ctl_r[dcc_pkg::CTL_DW_LSB +: 3];
  wire [2:0] src_xfer_width = ctl_r[dcc_pkg::CTL_SW_LSB +: 3];
  wire [1:0] dst_addr_step = ctl_r[dcc_pkg::CTL_DS_LSB +: 2];
  wire [1:0] src_addr_step = ctl_r[dcc_pkg::CTL_SS_LSB +: 2];
  wire [2:0] src_burst_len = ctl_r[dcc_pkg::CTL_SB_LSB +: 3];
  wire [5:0] src_bytes = width_bytes(src_xfer_width);
  wire [5:0] dst_bytes = width_bytes(dst_xfer_width);
  wire busy = state_r != dcc_pkg::S_IDLE;
  // register write decode
  wire wr_fire = aw_held_r && w_held_r && !bvalid_r;
  wire wr_src = wr_fire && awaddr_r == dcc_pkg::OFF_SRC;
  wire wr_dst = wr_fire && awaddr_r == dcc_pkg::OFF_DST;
  wire wr_cmd = wr_fire && awaddr_r == dcc_pkg::OFF_CMD;
  wire wr_mask = wr_fire && awaddr_r == dcc_pkg::OFF_MASK;
  wire wr_ctl = wr_fire && awaddr_r == dcc_pkg::OFF_CTL;
  wire wr_hit = wr_src | wr_dst | wr_cmd | wr_mask | wr_ctl
    | (wr_fire && awaddr_r == dcc_pkg::OFF_STAT);
  wire go = wr_cmd && wstrb_r[0] && wdata_r[dcc_pkg::CMD_GO] && !busy;
  // control and address register writes are ignored while a burst runs
  wire [16:0] ctl_wr = (ctl_r & ~wmask[16:0]) | (wdata_r[16:0] & wmask[16:0]);
  wire [31:0] src_wr = (src_addr_r & ~wmask) | (wdata_r & wmask);
  wire [31:0] dst_wr = (dst_addr_r & ~wmask) | (wdata_r & wmask);
  wire [STAT_W-1:0] mask_wr = (mask_r & ~wmask[STAT_W-1:0])
    | (wdata_r[STAT_W-1:0] & wmask[STAT_W-1:0]);
  // register read decode
  wire [7:0] ra = 8'(araddr);
  wire ar_fire = arvalid && arready_r;
  wire rd_stat = ra == dcc_pkg::OFF_STAT;
  wire rd_hit = rd_stat || ra == dcc_pkg::OFF_SRC || ra == dcc_pkg::OFF_DST
    || ra == dcc_pkg::OFF_CMD || ra == dcc_pkg::OFF_MASK
    || ra == dcc_pkg::OFF_CTL;
  wire [31:0] rd_mux =
      (ra == dcc_pkg::OFF_SRC) ? src_addr_r
    : (ra == dcc_pkg::OFF_DST) ? dst_addr_r
    : (ra == dcc_pkg::OFF_CMD) ? {31'h0, busy}
    : rd_stat ? {29'h0, busy, status_r}
    : (ra == dcc_pkg::OFF_MASK) ? {30'h0, mask_r}
    : (ra == dcc_pkg::OFF_CTL) ? {15'h0, ctl_r}
    : 32'h0;
  // bus engine events
  wire rd_done = state_r == dcc_pkg::S_RDATA && hready;
  wire wr_done = state_r == dcc_pkg::S_WDATA && hready;
  wire bus_err = (rd_done || wr_done) && hresp;
  wire last = cnt_r == 9'h001;
  wire blk_done = wr_done && !hresp && last;
  wire [31:0] src_nxt = wr_src && !busy ? src_wr
    : (rd_done && !hresp) ? step_addr(src_addr_r, src_addr_step, src_bytes)
    : src_addr_r; // [R1]
  wire [31:0] dst_nxt = wr_dst && !busy ? dst_wr
    : (wr_done && !hresp) ? step_addr(dst_addr_r, dst_addr_step, dst_bytes)
    : dst_addr_r; // [R3]
  // events set raw flags regardless of the channel irq enable
  wire [STAT_W-1:0] stat_set = {bus_err, blk_done}; // [R9]
  wire [STAT_W-1:0] stat_clr = (ar_fire && rd_stat) ? status_r : 2'h0;
  // a set in the clearing cycle survives
  wire [STAT_W-1:0] stat_nxt = stat_set | (status_r & ~stat_clr);
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      dcc_pkg::S_IDLE: if (go) state_nxt = dcc_pkg::S_RADDR;
      dcc_pkg::S_RADDR: if (hready) state_nxt = dcc_pkg::S_RDATA;
      dcc_pkg::S_RDATA:
        if (hready)
          state_nxt = hresp ? dcc_pkg::S_IDLE : dcc_pkg::S_WADDR;
      dcc_pkg::S_WADDR: if (hready) state_nxt = dcc_pkg::S_WDATA;
      dcc_pkg::S_WDATA:
        if (hready)
          state_nxt = (hresp || last) ? dcc_pkg::S_IDLE : dcc_pkg::S_RADDR;
      default: state_nxt = dcc_pkg::S_IDLE;
    endcase
  end
  wire next_wr = state_nxt == dcc_pkg::S_WADDR;
  wire next_addr = next_wr || state_nxt == dcc_pkg::S_RADDR;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= dcc_pkg::S_IDLE;
      src_addr_r <= 32'h0;
      dst_addr_r <= 32'h0;
      cnt_r <= 9'h0;
      htrans_r <= dcc_pkg::HTRANS_IDLE;
      haddr_r <= 32'h0;
      hwrite_r <= 1'b0;
      hsize_r <= 3'h0;
      hwdata_r <= 32'h0;
    end
    else
    begin
      state_r <= state_nxt;
      src_addr_r <= src_nxt;
      dst_addr_r <= dst_nxt;
      if (go)
        cnt_r <= burst_items(src_burst_len); // [R10]
      else if (wr_done)
        cnt_r <= cnt_r - 9'h001;
      htrans_r <= next_addr ? dcc_pkg::HTRANS_NONSEQ : dcc_pkg::HTRANS_IDLE;
      haddr_r <= next_wr ? dst_nxt : src_nxt;
      hwrite_r <= next_wr;
      // width codes map directly onto hsize
      hsize_r <= next_wr ? dst_xfer_width : src_xfer_width; // [R5] [R7]
      if (rd_done)
        hwdata_r <= hrdata;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl_r <= dcc_pkg::CTL_RST; // [R3] [R8] [R10]
      mask_r <= dcc_pkg::MASK_RST;
      status_r <= dcc_pkg::STAT_RST;
      irq_r <= 1'b0;
    end
    else
    begin
      if (wr_ctl && !busy)
        ctl_r <= ctl_wr;
      if (wr_mask)
        mask_r <= mask_wr;
      status_r <= stat_nxt;
      irq_r <= irq_en && |(stat_nxt & mask_r); // [R8]
    end
  end
  // write channel: address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= dcc_pkg::RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready_r)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= 8'(awaddr);
        awready_r <= 1'b0;
      end
      if (wvalid && wready_r)
      begin
        w_held_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
        wready_r <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_SLVERR;
      end
      if (bvalid_r && bready)
      begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= dcc_pkg::RESP_OKAY;
    end
    else
    begin
      if (ar_fire)
      begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= rd_hit ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_SLVERR;
      end
      else if (rvalid_r && rready)
      begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign haddr = haddr_r;
  assign htrans = htrans_r;
  assign hwrite = hwrite_r;
  assign hsize = hsize_r;
  assign hwdata = hwdata_r;
  assign irq = irq_r;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_src_beat;
    state_r == dcc_pkg::S_RDATA && hready && !hresp;
  endsequence
  sequence s_dst_beat;
    state_r == dcc_pkg::S_WDATA && hready && !hresp;
  endsequence
  src_inc_a: assert property ( // [R1]
    s_src_beat ##0 src_addr_step == 2'h0
    |=> src_addr_r - $past(src_addr_r) == {26'h0, $past(src_bytes)})
    else $error("source address did not increment");
  src_dec_a: assert property ( // [R1]
    s_src_beat ##0 src_addr_step == 2'h1
    |=> $past(src_addr_r) - src_addr_r == {26'h0, $past(src_bytes)})
    else $error("source address did not decrement");
  src_hold_a: assert property ( // [R1]
    s_src_beat ##0 src_addr_step[1] |=> $stable(src_addr_r))
    else $error("source address moved while held");
  dst_step_a: assert property ( // [R3]
    s_dst_beat ##0 dst_addr_step == 2'h0
    |=> dst_addr_r - $past(dst_addr_r) == {26'h0, $past(dst_bytes)})
    else $error("destination address did not increment");
  dst_hold_a: assert property ( // [R3]
    s_dst_beat ##0 dst_addr_step[1] |=> $stable(dst_addr_r))
    else $error("destination address moved while held");
  read_size_a: assert property ( // [R5]
    htrans_r == dcc_pkg::HTRANS_NONSEQ && !hwrite_r && !go
    && state_r == dcc_pkg::S_RADDR |-> hsize_r == src_xfer_width)
    else $error("source read hsize differs from programmed width");
  width_dec_a: assert property ( // [R7]
    src_xfer_width == 3'h2 |-> src_bytes == 6'h04)
    else $error("32-bit width not decoded as four bytes");
  wide_cap_a: assert property ( // [R7]
    dst_xfer_width >= 3'h5 |-> dst_bytes == 6'h20)
    else $error("top width codes not capped at 256 bits");
  irq_gate_a: assert property ( // [R8]
    !irq_en |=> !irq)
    else $error("interrupt raised with channel irq disabled");
  raw_set_a: assert property ( // [R9]
    blk_done |=> status_r[dcc_pkg::ST_DONE])
    else $error("block done flag not recorded");
  burst_len_a: assert property ( // [R10]
    go && src_burst_len == 3'h3 |=> cnt_r == 9'h010 ##0 busy)
    else $error("burst code 011 did not load sixteen items");
  bresp_hold_a: assert property (
    bvalid_r && !bready |=> bvalid_r && $stable(bresp_r))
    else $error("write response dropped before bready");
endmodule

// >>> hw/dcc_pkg.sv
package dcc_pkg;
  // register byte offsets on the control bus
  localparam logic [7:0] OFF_SRC = 8'h00;
  localparam logic [7:0] OFF_DST = 8'h04;
  localparam logic [7:0] OFF_CMD = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_MASK = 8'h10;
  localparam logic [7:0] OFF_CTL = 8'hc8;

  // control word field positions
  localparam int CTL_IRQ_EN = 0;
  localparam int CTL_DW_LSB = 1;
  localparam int CTL_SW_LSB = 4;
  localparam int CTL_DS_LSB = 7;
  localparam int CTL_SS_LSB = 9;
  localparam int CTL_DB_LSB = 11;
  localparam int CTL_SB_LSB = 14;
  localparam int CTL_W = 17;
  // both burst codes 001, both steps increment, widths 8 bit, irq on
  localparam logic [16:0] CTL_RST = 17'h04801;

  localparam logic [1:0] STEP_INC = 2'h0;
  localparam logic [1:0] STEP_DEC = 2'h1;
  localparam logic [2:0] WIDTH_CAP = 3'h5;
  localparam logic [5:0] BYTES_CAP = 6'h20;

  // status and mask layout
  localparam int ST_DONE = 0;
  localparam int ST_ERR = 1;
  localparam int ST_BUSY = 2;
  localparam int STAT_W = 2;
  localparam logic [1:0] STAT_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam int CMD_GO = 0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    S_IDLE,
    S_RADDR,
    S_RDATA,
    S_WADDR,
    S_WDATA
  } dcc_state_t;
endpackage

// >>> testbench/dcc_ahb_mem.sv
`timescale 1ns/1ns
module dcc_ahb_mem (
  input wire logic aclk,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hready,
  output logic hresp,
  input wire logic slow,
  input wire logic fail
);
  logic [31:0] rd_a [0:63];
  logic [31:0] wr_a [0:63];
  logic [31:0] wr_d [0:63];
  logic [2:0] rd_s [0:63];
  logic [2:0] wr_s [0:63];
  int n_rd = 0;
  int n_wr = 0;
  logic ph_rd = 1'b0;
  logic ph_wr = 1'b0;
  logic [31:0] ph_a = 32'h0;
  logic [2:0] ph_s = 3'h0;
  logic rdy_r = 1'b1;
  assign hready = rdy_r;
  // outside a read data phase the bus shows the inverse, never old data
  assign hrdata = {16'h0, 16'hc3a5} ^ {ph_a[15:0], 16'h0} ^ {32{~ph_rd}};
  assign hresp = fail & ph_rd & hready;
  always @(posedge aclk)
  begin
    rdy_r <= slow ? ~rdy_r : 1'b1;
    if (hready)
    begin
      if (ph_rd && n_rd < 64)
      begin
        rd_a[n_rd] <= ph_a;
        rd_s[n_rd] <= ph_s;
        n_rd <= n_rd + 1;
      end
      if (ph_wr && n_wr < 64)
      begin
        wr_a[n_wr] <= ph_a;
        wr_s[n_wr] <= ph_s;
        wr_d[n_wr] <= hwdata;
        n_wr <= n_wr + 1;
      end
      ph_rd <= htrans == 2'h2 && !hwrite;
      ph_wr <= htrans == 2'h2 && hwrite;
      ph_a <= haddr;
      ph_s <= hsize;
    end
  end
endmodule

// >>> testbench/dma_channel_ctrl_fields_tb.sv
`timescale 1ns/1ns
module dma_channel_ctrl_fields_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, haddr, hwdata, hrdata, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, slow = 1'b0, fail = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, hwrite, hready, hresp, irq;
  logic [1:0] bresp, rresp, htrans;
  logic [2:0] hsize;
  int n_fail = 0, checked = 0, cyc = 0;
  always #25 aclk = ~aclk;
  dcc_channel #(.ADDR_W(8)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata), .hready(hready),
    .hresp(hresp), .irq(irq));
  dcc_ahb_mem i_mem (.aclk(aclk), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
    .hready(hready), .hresp(hresp), .slow(slow), .fail(fail));
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  function automatic logic [31:0] ctl_w(int en, int dw, int sw, int ds,
    int ss, int sb);
    return 32'((en << dcc_pkg::CTL_IRQ_EN) | (dw << dcc_pkg::CTL_DW_LSB) |
      (sw << dcc_pkg::CTL_SW_LSB) | (ds << dcc_pkg::CTL_DS_LSB) |
      (ss << dcc_pkg::CTL_SS_LSB) | (sb << dcc_pkg::CTL_SB_LSB));
  endfunction
  task automatic run(input logic [31:0] c);
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(dcc_pkg::OFF_SRC, 32'h1000, r);
    axi_wr(dcc_pkg::OFF_DST, 32'h2000, r);
    axi_wr(dcc_pkg::OFF_CTL, c, r);
    chk(32'(r), 32'(dcc_pkg::RESP_OKAY));
    axi_wr(dcc_pkg::OFF_CMD, 32'h1, r);
    d = 32'h1;
    while (d[0] !== 1'b0) axi_rd(dcc_pkg::OFF_CMD, d, r);
    repeat (3) @(posedge aclk);
  endtask
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(dcc_pkg::OFF_CTL, d, r);
    chk(d, 32'(dcc_pkg::CTL_RST));
    axi_rd(8'h44, d, r);
    chk(32'(r), 32'(dcc_pkg::RESP_SLVERR));
    axi_wr(8'h44, 32'h0, r);
    chk(32'(r), 32'(dcc_pkg::RESP_SLVERR));
    axi_rd(dcc_pkg::OFF_STAT, d, r);
    chk(d, 32'h0);
    axi_rd(dcc_pkg::OFF_MASK, d, r);
    chk(d, 32'h0);
  endtask
  task automatic t_step();
    int dwt[4] = '{0, 1, 2, 5};
    int nit[4] = '{1, 4, 8, 16};
    int b_rd, b_wr, sd, dd, ds;
    logic [31:0] ea, c, d;
    logic [1:0] r;
    for (int i = 0; i < 4; i++)
    begin
      // hold codes stand for fixed-address fifos at either end
      ds = 3 - i;
      sd = i == 0 ? (1 << (i % 3)) : i == 1 ? -(1 << (i % 3)) : 0;
      dd = ds == 0 ? 32 : ds == 1 ? -4 : 0;
      b_rd = i_mem.n_rd;
      b_wr = i_mem.n_wr;
      slow <= i == 2;
      c = ctl_w(1, dwt[i], i % 3, ds, i, i);
      run(c);
      chk(32'(i_mem.n_rd - b_rd), 32'(nit[i]));
      chk(32'(i_mem.n_wr - b_wr), 32'(nit[i]));
      for (int k = 0; k < nit[i]; k++)
      begin
        ea = 32'(32'h1000 + k * sd);
        chk(i_mem.rd_a[b_rd + k], ea);
        chk(32'(i_mem.rd_s[b_rd + k]), 32'(i % 3));
        chk(i_mem.wr_a[b_wr + k], 32'(32'h2000 + k * dd));
        chk(i_mem.wr_d[b_wr + k], {ea[15:0], 16'hc3a5});
        chk(32'(i_mem.wr_s[b_wr + k]), 32'(dwt[i]));
      end
      axi_rd(dcc_pkg::OFF_CTL, d, r);
      chk(d, c);
      chk(32'(r), 32'(dcc_pkg::RESP_OKAY));
    end
    slow <= 1'b0;
  endtask
  task automatic t_irq();
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(dcc_pkg::OFF_MASK, 32'h3, r);
    run(ctl_w(1, 2, 2, 0, 0, 0));
    chk(32'(irq), 32'h1);
    axi_rd(dcc_pkg::OFF_STAT, d, r);
    chk(32'(d[0]), 32'h1);
    fail <= 1'b1;
    run(ctl_w(0, 2, 2, 0, 0, 1));
    fail <= 1'b0;
    chk(32'(irq), 32'h0);
    axi_wr(dcc_pkg::OFF_CTL, ctl_w(1, 2, 2, 0, 0, 1), r);
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'h1);
    axi_rd(dcc_pkg::OFF_STAT, d, r);
    chk(32'(d[1]), 32'h1);
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'h0);
  endtask
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      conclude();
    end
  end
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_step();
    t_irq();
    conclude();
  end
endmodule
